// file: rtl/strs_attr_rec.sv
// Purpose: Serialises one 12-byte attribute record of the counter attributes
// Assumes: Byte index 0..11, counts from the card's flash controller
// Notes: Combinational lookup, registered by the caller
`timescale 1ns/1ps
`include "strs_params.svh"
module strs_attr_rec import strs_pkg::*; (
	input wire logic sel_crc,
	input wire logic [3:0] idx,
	input wire logic [63:0] read_count,
	input wire logic [31:0] crc_count,
	output strs_byte_t data
);
	logic [63:0] cnt;
	always_comb begin
		// CRC record uses only bytes 4..7; 8..11 stay zero
		cnt = sel_crc ? {32'h0000_0000, crc_count} : read_count;
		case (idx)
			4'h0: data = sel_crc ? `STRS_ID_CRC : `STRS_ID_READS;
			4'h1: data = 8'(`STRS_ATTR_FLAGS);
			4'h2: data = 8'(`STRS_ATTR_FLAGS >> 8);
			4'h3: data = `STRS_FIXED_VALUE;
			4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB: data = cnt[8*(idx-4'h4) +: 8];
			default: data = 8'h00;
		endcase
	end
endmodule : strs_attr_rec

// file: rtl/strs_params.svh
// Purpose: Constants for the reliability threshold and status responder
// Assumes: Included by bare name from the RTL modules
// Notes: Definitions only
`ifndef STRS_PARAMS_SVH
`define STRS_PARAMS_SVH
`define STRS_CMD_RELIAB 8'hB0
`define STRS_CYL_HI_KEY 8'hC2
`define STRS_CYL_LO_KEY 8'h4F
`define STRS_FEAT_THRESH 8'hD1
`define STRS_FEAT_STATUS 8'hDA
`define STRS_CYL_LO_BAD 8'hF4
`define STRS_CYL_HI_BAD 8'h2C
`define STRS_STRUCT_VER 16'h0004
`define STRS_ID_SPARE 8'hC4
`define STRS_ID_ERASE 8'hE5
`define STRS_ID_ECC_TOT 8'hCB
`define STRS_ID_ECC_COR 8'hCC
`define STRS_ID_READS 8'hE8
`define STRS_ID_CRC 8'hC7
`define STRS_ATTR_FLAGS 16'h0002
`define STRS_FIXED_VALUE 8'h64
`define STRS_ENTRY_BYTES 12
`define STRS_NUM_ENTRIES 30
`define STRS_SECTOR_BYTES 512
`define STRS_ZERO_FIRST 362
`define STRS_NUM_USED 6
`define STRS_SPARE_THR_RST 8'h00
`define STRS_ERASE_THR_RST 8'h00
`endif

// file: rtl/strs_pkg.sv
// Purpose: Types for the reliability threshold and status responder
// Assumes: Constants come from strs_params.svh
// Notes: Types only
package strs_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_DONE} strs_state_t;
	typedef logic [7:0] strs_byte_t;
endpackage : strs_pkg

// file: rtl/strs_responder.sv
// Purpose: Reliability command handler: threshold sector and return status
// Assumes: Task file already latched; one command strobe per command
// Notes: Sector streams one byte per cycle with a valid strobe
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - Read-count record: id E8h, flags 0002h, value 64h, 64-bit count.
// - CRC record: id C7h, flags 0002h, value 64h, 32-bit count, rest zero.
// - Read and CRC counts never affect the status answer.
// - Command B0h, C2h/4Fh, feature D1h returns one 512-byte sector.
// - Sector: version 0004h, 30 entries of 12 bytes, zeros, checksum byte 511.
// - Entry: id in byte 0, threshold byte 1; spare C4h, erase E5h.
// - Read-count entry E8h carries a zero threshold.
// - ECC total CBh, ECC correctable CCh, CRC C7h entries carry zero threshold.
// - Command B0h, C2h/4Fh, feature DAh answers in the cylinder registers.
// - Exceeded spare or erase condition gives cylinder low F4h, high 2Ch.
// - No exceeded condition gives cylinder low 4Fh, high C2h.
// - Exceeded means attribute value below its stored threshold.
`timescale 1ns/1ps
`include "strs_params.svh"
module strs_responder import strs_pkg::*; #(
	parameter int SECTOR_BYTES = `STRS_SECTOR_BYTES
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CMD_STB,
	input wire logic [7:0] CMD_CODE,
	input wire logic [7:0] FEATURE,
	input wire logic [7:0] CYL_LO_IN,
	input wire logic [7:0] CYL_HI_IN,
	input wire logic [7:0] SPARE_VALUE,
	input wire logic [7:0] ERASE_VALUE,
	input wire logic [7:0] SPARE_THR,
	input wire logic [7:0] ERASE_THR,
	input wire logic THR_LOAD,
	input wire logic REC_SEL_CRC,
	input wire logic [3:0] REC_IDX,
	input wire logic [63:0] READ_COUNT,
	input wire logic [31:0] CRC_COUNT,
	output logic [7:0] REC_DATA,
	output logic [7:0] SECT_DATA,
	output logic SECT_VALID,
	output logic SECT_LAST,
	output logic BUSY,
	output logic DONE,
	output logic ABORT,
	output logic [7:0] CYL_LO_OUT,
	output logic [7:0] CYL_HI_OUT
);
	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		strs_state_t st;
		logic [8:0] idx;
		logic [7:0] sum;
		logic [7:0] spare_thr;
		logic [7:0] erase_thr;
		logic [7:0] sect_data;
		logic sect_valid;
		logic sect_last;
		logic done;
		logic abort;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
		logic [7:0] rec_data;
		logic busy;
	} strs_regs_t;
	strs_regs_t r_q, r_d;
	strs_byte_t rec_byte;

	strs_attr_rec u_rec (
		.sel_crc(REC_SEL_CRC),
		.idx(REC_IDX),
		.read_count(READ_COUNT),
		.crc_count(CRC_COUNT),
		.data(rec_byte)
	);

	//------------------------------------------------------------
	// Decode helpers
	//------------------------------------------------------------
	// Reliability command with the cylinder key and the wanted feature
	function automatic logic req_match(input logic [7:0] code, input logic [7:0] feat,
		input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] want);
		req_match = (code == `STRS_CMD_RELIAB) && (hi == `STRS_CYL_HI_KEY)
			&& (lo == `STRS_CYL_LO_KEY) && (feat == want);
	endfunction : req_match

	// Byte 0 of an entry is its identifier, byte 1 its threshold
	function automatic strs_byte_t entry_byte(input logic [8:0] pos, input strs_byte_t id,
		input strs_byte_t thr);
		entry_byte = (pos == 9'd0) ? id : thr;
	endfunction : entry_byte

	//------------------------------------------------------------
	// Threshold sector content
	//------------------------------------------------------------
	function automatic strs_byte_t sector_byte(input logic [8:0] i, input logic [7:0] sp,
		input logic [7:0] er);
		logic [8:0] off;
		logic [8:0] ent;
		logic [8:0] pos;
		off = 9'd0;
		ent = 9'd0;
		pos = 9'd0;
		sector_byte = 8'h00;
		if (i == 9'd0) begin
			sector_byte = 8'(`STRS_STRUCT_VER);
		end else if (i == 9'd1) begin
			sector_byte = 8'(`STRS_STRUCT_VER >> 8);
		end else if (i < 9'(`STRS_ZERO_FIRST)) begin
			off = i - 9'd2;
			ent = off / 9'(`STRS_ENTRY_BYTES);
			pos = off % 9'(`STRS_ENTRY_BYTES);
			// Unused entries are all zero; only byte 0 and 1 ever nonzero
			if (ent < 9'(`STRS_NUM_USED) && pos < 9'd2) begin
				case (ent[2:0])
					3'd0: sector_byte = entry_byte(pos, `STRS_ID_SPARE, sp);
					3'd1: sector_byte = entry_byte(pos, `STRS_ID_ERASE, er);
					3'd2: sector_byte = entry_byte(pos, `STRS_ID_ECC_TOT, 8'h00);
					3'd3: sector_byte = entry_byte(pos, `STRS_ID_ECC_COR, 8'h00);
					3'd4: sector_byte = entry_byte(pos, `STRS_ID_READS, 8'h00);
					3'd5: sector_byte = entry_byte(pos, `STRS_ID_CRC, 8'h00);
					default: sector_byte = 8'h00;
				endcase
			end
		end
	endfunction : sector_byte

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	logic want_thr;
	logic want_stat;
	logic exceeded;
	strs_byte_t b;
	always_comb begin
		r_d = r_q;
		b = 8'h00;
		r_d.sect_valid = 1'b0;
		r_d.sect_last = 1'b0;
		r_d.done = 1'b0;
		r_d.abort = 1'b0;
		r_d.rec_data = rec_byte;
		// Drive/head and sector registers are ignored
		want_thr = req_match(CMD_CODE, FEATURE, CYL_LO_IN, CYL_HI_IN, `STRS_FEAT_THRESH);
		want_stat = req_match(CMD_CODE, FEATURE, CYL_LO_IN, CYL_HI_IN, `STRS_FEAT_STATUS);
		// Only spare and erase judged; read and CRC counts not inputs
		exceeded = (SPARE_VALUE < r_q.spare_thr) || (ERASE_VALUE < r_q.erase_thr);
		// Loads only while idle, so a sector never mixes old and new thresholds
		if (THR_LOAD && r_q.st == ST_IDLE) begin
			r_d.spare_thr = SPARE_THR;
			r_d.erase_thr = ERASE_THR;
		end
		case (r_q.st)
			ST_IDLE: begin
				if (CMD_STB) begin
					if (want_thr) begin
						r_d.st = ST_SEND;
						r_d.idx = 9'd0;
						r_d.sum = 8'h00;
					end else if (want_stat) begin
						r_d.cyl_lo = exceeded ? `STRS_CYL_LO_BAD : `STRS_CYL_LO_KEY;
						r_d.cyl_hi = exceeded ? `STRS_CYL_HI_BAD : `STRS_CYL_HI_KEY;
						r_d.done = 1'b1;
					end else begin
						// Unknown feature or missing key is aborted
						r_d.abort = 1'b1;
					end
				end
			end
			ST_SEND: begin
				// No back-pressure: one byte leaves every cycle up to the checksum
				b = sector_byte(r_q.idx, r_q.spare_thr, r_q.erase_thr);
				r_d.sect_valid = 1'b1;
				if (r_q.idx == 9'(SECTOR_BYTES - 1)) begin
					r_d.sect_data = 8'(8'h00 - r_q.sum);
					r_d.sect_last = 1'b1;
					r_d.st = ST_DONE;
				end else begin
					r_d.sect_data = b;
					r_d.sum = 8'(r_q.sum + b);
					r_d.idx = 9'(r_q.idx + 9'd1);
				end
			end
			ST_DONE: begin
				r_d.done = 1'b1;
				r_d.st = ST_IDLE;
			end
			default: r_d.st = ST_IDLE;
		endcase
		// Busy follows the next state, so it rises the cycle after an accepted sector request
		r_d.busy = (r_d.st != ST_IDLE);
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			r_q <= '0;
			r_q.st <= ST_IDLE;
			r_q.spare_thr <= `STRS_SPARE_THR_RST;
			r_q.erase_thr <= `STRS_ERASE_THR_RST;
			r_q.cyl_lo <= `STRS_CYL_LO_KEY;
			r_q.cyl_hi <= `STRS_CYL_HI_KEY;
		end else begin
			r_q <= r_d;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	assign BUSY = r_q.busy;
	assign REC_DATA = r_q.rec_data;
	assign SECT_DATA = r_q.sect_data;
	assign SECT_VALID = r_q.sect_valid;
	assign SECT_LAST = r_q.sect_last;
	assign DONE = r_q.done;
	assign ABORT = r_q.abort;
	assign CYL_LO_OUT = r_q.cyl_lo;
	assign CYL_HI_OUT = r_q.cyl_hi;
endmodule : strs_responder

// file: tb/strs_checker.sv
// Purpose: Port-level checks of the reliability responder
// Assumes: Thresholds tracked here from the load pins
// Notes: Bound from the bench
`timescale 1ns/1ps
module strs_checker #(
	parameter int SECTOR_BYTES = 512
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CMD_STB,
	input wire logic [7:0] CMD_CODE,
	input wire logic [7:0] FEATURE,
	input wire logic [7:0] CYL_LO_IN,
	input wire logic [7:0] CYL_HI_IN,
	input wire logic [7:0] SPARE_VALUE,
	input wire logic [7:0] ERASE_VALUE,
	input wire logic [7:0] SPARE_THR,
	input wire logic [7:0] ERASE_THR,
	input wire logic THR_LOAD,
	input wire logic REC_SEL_CRC,
	input wire logic [3:0] REC_IDX,
	input wire logic [7:0] REC_DATA,
	input wire logic SECT_VALID,
	input wire logic SECT_LAST,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic ABORT,
	input wire logic [7:0] CYL_LO_OUT,
	input wire logic [7:0] CYL_HI_OUT
);
	logic [7:0] st_q, et_q;
	logic [9:0] n_q;
	wire key = CMD_STB && !BUSY && !SECT_VALID && CMD_CODE == 8'hB0;
	wire ok = key && CYL_LO_IN == 8'h4F && CYL_HI_IN == 8'hC2;
	wire sreq = ok && FEATURE == 8'hDA;
	wire bad = SPARE_VALUE < st_q || ERASE_VALUE < et_q;
	always_ff @(posedge CLK) begin
		st_q <= !RESETN ? 8'h00 : (THR_LOAD && !BUSY) ? SPARE_THR : st_q;
		et_q <= !RESETN ? 8'h00 : (THR_LOAD && !BUSY) ? ERASE_THR : et_q;
		n_q <= SECT_VALID ? n_q + 10'h1 : 10'h0;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	stat_bad_a: assert property (sreq && bad |=> CYL_LO_OUT == 8'hF4 && CYL_HI_OUT == 8'h2C)
		else $error("status not flagged");
	stat_ok_a: assert property (sreq && !bad |=> CYL_LO_OUT == 8'h4F && CYL_HI_OUT == 8'hC2)
		else $error("status wrongly flagged");
	bad_key_a: assert property (key && !(ok && (FEATURE == 8'hD1 || sreq)) |=> ABORT && !DONE)
		else $error("bad request not refused");
	sect_start_a: assert property (ok && FEATURE == 8'hD1 |=> BUSY ##1 SECT_VALID)
		else $error("sector did not start");
	sect_len_a: assert property (SECT_LAST |-> SECT_VALID && n_q == 10'(SECTOR_BYTES - 1))
		else $error("sector length wrong");
	sect_end_a: assert property ($fell(SECT_VALID) |-> DONE && $past(SECT_LAST))
		else $error("sector end wrong");
	rec_id_a: assert property (REC_IDX == 4'h0 |=> REC_DATA == ($past(REC_SEL_CRC) ? 8'hC7 : 8'hE8))
		else $error("record id wrong");
	rec_value_a: assert property (REC_IDX == 4'h3 |=> REC_DATA == 8'h64)
		else $error("record value wrong");
	crc_unused_a: assert property (REC_SEL_CRC && REC_IDX > 4'h7 |=> REC_DATA == 8'h00)
		else $error("unused byte not zero");
	bad_cmd_a: assert property (CMD_STB && !BUSY && !SECT_VALID && CMD_CODE != 8'hB0 |=> ABORT)
		else $error("foreign command not refused");
endmodule : strs_checker

// file: tb/strs_host.sv
// Purpose: Host side of the task file for reliability commands
// Assumes: One command at a time; caller waits for completion
// Notes: Released lines show the inverse of the last value
`timescale 1ns/1ps
module strs_host (
	input wire logic clk,
	output logic stb,
	output logic [7:0] code,
	output logic [7:0] feat,
	output logic [7:0] lo,
	output logic [7:0] hi
);
	initial stb = 1'h0;
	initial {code, feat, lo, hi} = 32'h0;
	task issue(input logic [7:0] c, input logic [7:0] f, input logic [7:0] l,
		input logic [7:0] h);
		@(posedge clk);
		stb <= 1'h1;
		code <= c;
		feat <= f;
		lo <= l;
		hi <= h;
		@(posedge clk);
		stb <= 1'h0;
		// Drive/head and sector lines are not wired, so nothing to hold
		{code, feat, lo, hi} <= ~{code, feat, lo, hi};
	endtask : issue
endmodule : strs_host

// file: tb/strs_responder_bench.sv
// Purpose: Self-checking bench of the reliability responder
// Assumes: Default sector length
// Notes: Waits sample at the falling edge
`timescale 1ns/1ps
module strs_responder_bench;
	logic CLK = 1'h0;
	logic RESETN = 1'h0;
	logic THR_LOAD = 1'h0;
	logic REC_SEL_CRC = 1'h0;
	logic [3:0] REC_IDX = 4'h0;
	logic [7:0] SPARE_VALUE = 8'h10, ERASE_VALUE = 8'h10, SPARE_THR = 8'h0, ERASE_THR = 8'h0;
	// Large nonzero counts must not sway the status answer
	logic [63:0] READ_COUNT = 64'hFEDC_BA98_7654_3210;
	logic [31:0] CRC_COUNT = 32'hF1E2_D3C4;
	logic CMD_STB, SECT_VALID, SECT_LAST, BUSY, DONE, ABORT;
	logic [7:0] CMD_CODE, FEATURE, CYL_LO_IN, CYL_HI_IN, REC_DATA, SECT_DATA;
	logic [7:0] CYL_LO_OUT, CYL_HI_OUT;
	logic [7:0] ids [6] = '{8'hC4, 8'hE5, 8'hCB, 8'hCC, 8'hE8, 8'hC7};
	int errors = 0;
	int checked = 0;
	always #12.5 CLK = ~CLK;
	strs_host host (.clk(CLK), .stb(CMD_STB), .code(CMD_CODE), .feat(FEATURE), .lo(CYL_LO_IN),
		.hi(CYL_HI_IN));
	strs_responder uut (.CLK, .RESETN, .CMD_STB, .CMD_CODE, .FEATURE, .CYL_LO_IN, .CYL_HI_IN,
		.SPARE_VALUE, .ERASE_VALUE, .SPARE_THR, .ERASE_THR, .THR_LOAD, .REC_SEL_CRC, .REC_IDX,
		.READ_COUNT, .CRC_COUNT, .REC_DATA, .SECT_DATA, .SECT_VALID, .SECT_LAST, .BUSY, .DONE,
		.ABORT, .CYL_LO_OUT, .CYL_HI_OUT);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task conclude;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	task automatic wait_hi(ref logic s);
		int n;
		for (n = 0; n < 40 && s !== 1'h1; n++)
			@(negedge CLK);
		if (n == 40) begin
			errors++;
			conclude();
		end
	endtask : wait_hi
	task stat(input logic [7:0] sv, ev, lo, hi);
		@(posedge CLK);
		SPARE_VALUE <= sv;
		ERASE_VALUE <= ev;
		host.issue(8'hB0, 8'hDA, 8'h4F, 8'hC2);
		wait_hi(DONE);
		chk(CYL_LO_OUT, lo);
		chk(CYL_HI_OUT, hi);
	endtask : stat
	function automatic logic [7:0] exp_b(input int i);
		int k;
		int o;
		k = (i - 2) / 12;
		o = (i - 2) % 12;
		if (i < 2)
			return i == 0 ? 8'h04 : 8'h00;
		if (k > 5 || o > 1)
			return 8'h00;
		if (o == 0)
			return ids[k];
		return k == 0 ? 8'h50 : k == 1 ? 8'h40 : 8'h00;
	endfunction : exp_b
	task sect;
		logic [7:0] sum;
		sum = 8'h00;
		host.issue(8'hB0, 8'hD1, 8'h4F, 8'hC2);
		wait_hi(SECT_VALID);
		for (int i = 0; i < 512; i++) begin
			chk({7'h0, SECT_LAST}, {7'h0, i == 511});
			if (i < 511)
				chk(SECT_DATA, exp_b(i));
			sum = sum + SECT_DATA;
			// A threshold load while the sector streams must be ignored
			if (i == 100 || i == 101) begin
				@(posedge CLK);
				{SPARE_THR, THR_LOAD} <= {8'hFF, i == 100};
			end
			@(negedge CLK);
		end
		chk(sum, 8'h00);
		chk({6'h0, DONE, SECT_VALID}, 8'h02);
	endtask : sect
	task recs;
		logic [7:0] e;
		for (int i = 0; i < 24; i++) begin
			@(posedge CLK);
			REC_SEL_CRC <= i > 11;
			REC_IDX <= 4'(i % 12);
			@(posedge CLK);
			@(negedge CLK);
			e = REC_IDX == 0 ? (REC_SEL_CRC ? 8'hC7 : 8'hE8) : REC_IDX == 1 ? 8'h02 : REC_IDX == 3 ?
				8'h64 : REC_IDX < 4 || REC_IDX > 7 && REC_SEL_CRC ? 8'h00 : REC_SEL_CRC ?
				CRC_COUNT[8 * (REC_IDX - 4) +: 8] : READ_COUNT[8 * (REC_IDX - 4) +: 8];
			chk(REC_DATA, e);
		end
	endtask : recs
	initial begin
		repeat (16) @(posedge CLK);
		RESETN <= 1'h1;
		stat(8'h10, 8'h10, 8'h4F, 8'hC2);
		@(posedge CLK);
		{SPARE_THR, ERASE_THR, THR_LOAD} <= {8'h50, 8'h40, 1'h1};
		@(posedge CLK);
		THR_LOAD <= 1'h0;
		stat(8'h50, 8'h40, 8'h4F, 8'hC2);
		stat(8'h4F, 8'h40, 8'hF4, 8'h2C);
		stat(8'h50, 8'h3F, 8'hF4, 8'h2C);
		host.issue(8'hB0, 8'hDA, 8'h4E, 8'hC2);
		wait_hi(ABORT);
		host.issue(8'hB1, 8'hDA, 8'h4F, 8'hC2);
		wait_hi(ABORT);
		host.issue(8'hB0, 8'hD0, 8'h4F, 8'hC2);
		wait_hi(ABORT);
		sect();
		stat(8'h50, 8'h40, 8'h4F, 8'hC2);
		recs();
		conclude();
	end
endmodule : strs_responder_bench
bind strs_responder strs_checker #(.SECTOR_BYTES(SECTOR_BYTES)) chk_i (.CLK, .RESETN, .CMD_STB,
	.CMD_CODE, .FEATURE, .CYL_LO_IN, .CYL_HI_IN, .SPARE_VALUE, .ERASE_VALUE, .SPARE_THR,
	.ERASE_THR, .THR_LOAD, .REC_SEL_CRC, .REC_IDX, .REC_DATA, .SECT_VALID, .SECT_LAST, .BUSY,
	.DONE, .ABORT, .CYL_LO_OUT, .CYL_HI_OUT);
